// File: design/pack_prot_pkg.sv
// shared constants, field layouts and carrier types for the pack protection config block
package pack_prot_pkg;

	// register byte addresses on the serial register port
	localparam logic [7:0] ADDR_DIS_CFG  = 8'h05;
	localparam logic [7:0] ADDR_CHG_CFG  = 8'h06;
	localparam logic [7:0] ADDR_FEAT_CFG = 8'h07;
	localparam logic [7:0] ADDR_WEN      = 8'h08;

	// reset value of every register, and the read value of unmapped addresses
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// writable bits of the write-enable register; low three are reserved
	localparam logic [7:0] WEN_WRITE_MASK = 8'hF8;

	// clock
	localparam int unsigned CLK_PERIOD_NS = 50;

	// times in their own units
	localparam int unsigned CHG_OC_BASE_MS   = 80;
	localparam int unsigned DIS_OC_BASE_MS   = 160;
	localparam int unsigned SHORT_SHORT_US   = 190;
	localparam int unsigned SHORT_LONG_MS    = 10;
	localparam int unsigned SCAN_ON_MS       = 5;
	localparam int unsigned SCAN_PERIOD_MS   = 640;

	// least times round up to whole cycles
	localparam int unsigned CHG_OC_BASE_CYC =
		(CHG_OC_BASE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DIS_OC_BASE_CYC =
		(DIS_OC_BASE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SHORT_SHORT_CYC =
		(SHORT_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SHORT_LONG_CYC =
		(SHORT_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SCAN_ON_CYC =
		(SCAN_ON_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SCAN_PERIOD_CYC =
		(SCAN_PERIOD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// time-scale dividers as shift amounts (32 and 64)
	localparam logic [4:0] CHG_TIME_SHIFT = 5'h05;
	localparam logic [4:0] DIS_TIME_SHIFT = 5'h06;

	// charge threshold ladder in millivolts
	localparam logic [7:0] THR_BASE_MV = 8'h64;
	localparam logic [7:0] THR_STEP_MV = 8'h14;

	// charge / time-scale configuration layout
	typedef struct packed {
		logic       auto_off_disable;
		logic [1:0] threshold;
		logic       short_long_delay;
		logic       chg_time_scale;
		logic       dis_time_scale;
		logic [1:0] delay;
	} chg_cfg_s;

	// feature configuration layout
	typedef struct packed {
		logic auto_temp_scan_off;
		logic regulator_disable;
		logic sensor_supply_force;
		logic ext_thermal_off_disable;
		logic int_thermal_off_disable;
		logic force_por;
		logic wake_pin_disable;
		logic wake_edge_select;
	} feat_cfg_s;

	// write-enable register layout
	typedef struct packed {
		logic       feature_cfg_write_en;
		logic       charge_cfg_write_en;
		logic       discharge_cfg_write_en;
		logic       user_flag_b;
		logic       user_flag_a;
		logic [2:0] reserved;
	} wen_s;

	// one register access from the serial front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_access_s;

	// delay in cycles: base doubled per code step, optionally divided by a power of two
	function automatic logic [31:0] delay_cycles(input logic [31:0] base, input logic [1:0] code,
			input logic scale_en, input logic [4:0] shift);
		logic [31:0] d;
		d = base << code;
		delay_cycles = scale_en ? (d >> shift) : d;
	endfunction

endpackage

// File: design/pack_protection_config_regs.sv
// configuration registers and protection sequencing of the pack protection front end
`timescale 1ns/100ps
`default_nettype none
module pack_protection_config_regs
	import pack_prot_pkg::*;
#(
	parameter logic [31:0] CHG_OC_BASE_CYCLES  = CHG_OC_BASE_CYC,
	parameter logic [31:0] DIS_OC_BASE_CYCLES  = DIS_OC_BASE_CYC,
	parameter logic [31:0] SHORT_LONG_CYCLES   = SHORT_LONG_CYC,
	parameter logic [31:0] SCAN_ON_CYCLES      = SCAN_ON_CYC,
	parameter logic [31:0] SCAN_PERIOD_CYCLES  = SCAN_PERIOD_CYC
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// register access from the serial front end
	input  wire reg_access_s reg_req_i,
	output logic [7:0]       reg_rdata_o,
	// discharge register forwarding
	output logic             dis_cfg_wr_o,
	output logic [7:0]       dis_cfg_wdata_o,
	input  wire logic [1:0]  dis_oc_delay_code_i,
	output logic [31:0]      dis_oc_delay_cycles_o,
	// analog conditions
	input  wire logic        chg_oc_detect_i,
	input  wire logic        short_detect_i,
	input  wire logic        ext_overtemp_i,
	input  wire logic        int_overtemp_i,
	input  wire logic        wake_pin_i,
	// flag clears from the status register
	input  wire logic        chg_oc_flag_clr_i,
	input  wire logic        ext_ot_flag_clr_i,
	input  wire logic        int_ot_flag_clr_i,
	// status flags
	output logic             chg_overcurrent_flag_o,
	output logic             ext_overtemp_flag_o,
	output logic             int_overtemp_flag_o,
	// protection actions
	output logic             fet_shutdown_o,
	output logic             charge_switch_clear_o,
	output logic             short_trip_o,
	output logic [1:0]       chg_oc_threshold_o,
	output logic [7:0]       chg_oc_threshold_mv_o,
	output logic [31:0]      chg_oc_delay_cycles_o,
	// supplies and wake
	output logic             sensor_supply_out_o,
	output logic             regulator_disable_o,
	output logic             wake_o
);
	// configuration registers
	chg_cfg_s  chg_cfg_reg;                 // charge / time-scale config
	feat_cfg_s feat_cfg_reg;                // feature config
	wen_s      wen_reg;                     // write enables and user flags
	logic      por_pending_reg;             // forced reset scheduled for next cycle

	// decoded accesses
	logic      wr_chg;
	logic      wr_feat;
	logic      wr_wen;
	logic      wr_dis;
	logic [7:0] rd_mux;
	feat_cfg_s feat_wdata;

	// derived timing
	logic [31:0] chg_delay;
	logic [31:0] dis_delay;
	logic [31:0] short_delay;
	logic        chg_fire;
	logic        short_fire;
	logic        scan_on;

	// flags and actions
	logic chg_flag_reg;
	logic ext_flag_reg;
	logic int_flag_reg;
	logic fet_off_reg;
	logic chg_clear_reg;
	logic short_trip_reg;
	logic supply_reg;
	logic [1:0]  thr_code_reg;
	logic [7:0]  thr_mv_reg;
	logic [31:0] chg_delay_reg;
	logic [31:0] dis_delay_reg;
	logic [7:0]  rdata_reg;
	logic        dis_wr_reg;
	logic [7:0]  dis_wdata_reg;
	logic        shut_next;

	// wake edge detection
	logic wake_prev_reg;
	logic wake_armed_reg;
	logic wake_reg;
	logic wake_edge;

	// threshold ladder: base plus one step per code
	function automatic logic [7:0] threshold_mv(input logic [1:0] code);
		threshold_mv = THR_BASE_MV + (THR_STEP_MV * {6'h00, code});
	endfunction

	// write decode; protected registers need their enable bit
	assign wr_feat = reg_req_i.wr && (reg_req_i.addr == ADDR_FEAT_CFG)
		&& wen_reg.feature_cfg_write_en;
	assign wr_chg  = reg_req_i.wr && (reg_req_i.addr == ADDR_CHG_CFG)
		&& wen_reg.charge_cfg_write_en;
	assign wr_dis  = reg_req_i.wr && (reg_req_i.addr == ADDR_DIS_CFG)
		&& wen_reg.discharge_cfg_write_en;
	assign wr_wen  = reg_req_i.wr && (reg_req_i.addr == ADDR_WEN);
	assign feat_wdata = feat_cfg_s'(reg_req_i.data);

	// read select; the forced-reset bit reads back as set only in the one cycle before the forced reset clears it
	assign rd_mux =
		(reg_req_i.addr == ADDR_CHG_CFG)  ? 8'(chg_cfg_reg) :
		(reg_req_i.addr == ADDR_FEAT_CFG) ? 8'(feat_cfg_reg) :
		(reg_req_i.addr == ADDR_WEN)      ? (8'(wen_reg) & WEN_WRITE_MASK) :
		READ_UNMAPPED;

	// delay selection
	assign chg_delay = delay_cycles(CHG_OC_BASE_CYCLES, chg_cfg_reg.delay,
		chg_cfg_reg.chg_time_scale, CHG_TIME_SHIFT);
	assign dis_delay = delay_cycles(DIS_OC_BASE_CYCLES, dis_oc_delay_code_i,
		chg_cfg_reg.dis_time_scale, DIS_TIME_SHIFT);
	assign short_delay = chg_cfg_reg.short_long_delay ? SHORT_LONG_CYCLES
		: 32'(SHORT_SHORT_CYC);

	// wake edge according to polarity, blocked by the disable bit
	assign wake_edge = wake_armed_reg && !feat_cfg_reg.wake_pin_disable &&
		(feat_cfg_reg.wake_edge_select ? (wake_pin_i && !wake_prev_reg)
		: (!wake_pin_i && wake_prev_reg));

	// automatic FET shutdown from charge OC or either overtemperature
	assign shut_next = (chg_fire && !chg_cfg_reg.auto_off_disable)
		|| (ext_overtemp_i && !feat_cfg_reg.ext_thermal_off_disable)
		|| (int_overtemp_i && !feat_cfg_reg.int_thermal_off_disable);

	// charge overcurrent persistence
	persist_timer #(
		.WIDTH(32)
	) u_chg_timer (
		.ref_clk_i(ref_clk_i),
		.rst_i    (rst_i),
		.clr_i    (por_pending_reg),
		.active_i (chg_oc_detect_i),
		.limit_i  (chg_delay),
		.fire_o   (chg_fire)
	);

	// short circuit persistence
	persist_timer #(
		.WIDTH(32)
	) u_short_timer (
		.ref_clk_i(ref_clk_i),
		.rst_i    (rst_i),
		.clr_i    (por_pending_reg),
		.active_i (short_detect_i),
		.limit_i  (short_delay),
		.fire_o   (short_fire)
	);

	// periodic external temperature scan
	scan_sequencer #(
		.WIDTH(32)
	) u_scan (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.clr_i       (por_pending_reg),
		.enable_i    (!feat_cfg_reg.auto_temp_scan_off),
		.on_cyc_i    (SCAN_ON_CYCLES),
		.period_cyc_i(SCAN_PERIOD_CYCLES),
		.scan_on_o   (scan_on)
	);

	// configuration registers; forced reset wins over any write in flight
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			chg_cfg_reg  <= chg_cfg_s'(REG_RESET);
			feat_cfg_reg <= feat_cfg_s'(REG_RESET);
			wen_reg      <= wen_s'(REG_RESET);
		end else if (por_pending_reg) begin
			chg_cfg_reg  <= chg_cfg_s'(REG_RESET);
			feat_cfg_reg <= feat_cfg_s'(REG_RESET);
			wen_reg      <= wen_s'(REG_RESET);
		end else begin
			if (wr_chg)
				chg_cfg_reg <= chg_cfg_s'(reg_req_i.data);
			if (wr_feat)
				feat_cfg_reg <= feat_wdata;
			// user flags are touched only by writes and resets, never by regulator state
			if (wr_wen)
				wen_reg <= wen_s'(reg_req_i.data & WEN_WRITE_MASK);
		end
	end

	// forced reset: one cycle after the write, config registers, flags, actions, timers and scan return to zero
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			por_pending_reg <= 1'b0;
		else
			por_pending_reg <= !por_pending_reg && wr_feat && feat_wdata.force_por;
	end

	// status flags; a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			chg_flag_reg <= 1'b0;
			ext_flag_reg <= 1'b0;
			int_flag_reg <= 1'b0;
		end else if (por_pending_reg) begin
			chg_flag_reg <= 1'b0;
			ext_flag_reg <= 1'b0;
			int_flag_reg <= 1'b0;
		end else begin
			chg_flag_reg <= chg_fire || (chg_flag_reg && !chg_oc_flag_clr_i);
			ext_flag_reg <= ext_overtemp_i || (ext_flag_reg && !ext_ot_flag_clr_i);
			int_flag_reg <= int_overtemp_i || (int_flag_reg && !int_ot_flag_clr_i);
		end
	end

	// protection actions and sensor supply
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fet_off_reg    <= 1'b0;
			chg_clear_reg  <= 1'b0;
			short_trip_reg <= 1'b0;
			supply_reg     <= 1'b0;
		end else if (por_pending_reg) begin
			fet_off_reg    <= 1'b0;
			chg_clear_reg  <= 1'b0;
			short_trip_reg <= 1'b0;
			supply_reg     <= 1'b0;
		end else begin
			fet_off_reg    <= shut_next;
			chg_clear_reg  <= chg_fire && !chg_cfg_reg.auto_off_disable;
			short_trip_reg <= short_fire;
			// supply follows flag, force bit and scan window
			supply_reg     <= chg_flag_reg || feat_cfg_reg.sensor_supply_force
				|| scan_on;
		end
	end

	// registered copies of the selections, so every output leaves a flop
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			thr_code_reg  <= 2'h0;
			thr_mv_reg    <= THR_BASE_MV;
			chg_delay_reg <= CHG_OC_BASE_CYCLES;
			dis_delay_reg <= DIS_OC_BASE_CYCLES;
		end else begin
			thr_code_reg  <= chg_cfg_reg.threshold;
			thr_mv_reg    <= threshold_mv(chg_cfg_reg.threshold);
			chg_delay_reg <= chg_delay;
			dis_delay_reg <= dis_delay;
		end
	end

	// register read data and discharge write forwarding
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg     <= READ_UNMAPPED;
			dis_wr_reg    <= 1'b0;
			dis_wdata_reg <= REG_RESET;
		end else begin
			if (reg_req_i.rd)
				rdata_reg <= rd_mux;
			dis_wr_reg <= wr_dis && !por_pending_reg;
			if (wr_dis)
				dis_wdata_reg <= reg_req_i.data;
		end
	end

	// wake pin history; armed after one sample so reset cannot fake an edge
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_prev_reg  <= 1'b0;
			wake_armed_reg <= 1'b0;
			wake_reg       <= 1'b0;
		end else begin
			wake_prev_reg  <= wake_pin_i;
			wake_armed_reg <= 1'b1;
			wake_reg       <= wake_edge;
		end
	end

	// outputs
	assign reg_rdata_o            = rdata_reg;
	assign dis_cfg_wr_o           = dis_wr_reg;
	assign dis_cfg_wdata_o        = dis_wdata_reg;
	assign dis_oc_delay_cycles_o  = dis_delay_reg;
	assign chg_overcurrent_flag_o = chg_flag_reg;
	assign ext_overtemp_flag_o    = ext_flag_reg;
	assign int_overtemp_flag_o    = int_flag_reg;
	assign fet_shutdown_o         = fet_off_reg;
	assign charge_switch_clear_o  = chg_clear_reg;
	assign short_trip_o           = short_trip_reg;
	assign chg_oc_threshold_o     = thr_code_reg;
	assign chg_oc_threshold_mv_o  = thr_mv_reg;
	assign chg_oc_delay_cycles_o  = chg_delay_reg;
	assign sensor_supply_out_o    = supply_reg;
	assign regulator_disable_o    = feat_cfg_reg.regulator_disable;
	assign wake_o                 = wake_reg;
endmodule
`default_nettype wire

// File: design/persist_timer.sv
// persistence timer: fires once a condition has held for a programmed cycle count
`timescale 1ns/100ps
`default_nettype none
module persist_timer #(
	parameter int unsigned WIDTH = 32
) (
	// clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic             clr_i,      // synchronous clear
	// condition and limit
	input  wire logic             active_i,   // condition present
	input  wire logic [WIDTH-1:0] limit_i,    // cycles it must hold, at least one
	// result
	output logic                  fire_o      // one-cycle pulse on reaching limit
);
	logic [WIDTH-1:0] cnt_reg;                // cycles held so far
	logic [WIDTH-1:0] cnt_next;
	logic             done_reg;               // fired during this episode
	logic             reach;                  // this cycle completes the hold
	logic             fire_reg;

	// a limit changed mid-episode takes effect at once; the count is not restarted
	assign reach    = active_i && !done_reg && ((cnt_reg + 1'b1) >= limit_i);
	assign cnt_next = (!active_i || done_reg) ? '0 : cnt_reg + 1'b1;
	assign fire_o   = fire_reg;

	// count while the condition holds, drop to zero as soon as it goes away
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg  <= '0;
			done_reg <= 1'b0;
			fire_reg <= 1'b0;
		end else if (clr_i) begin
			cnt_reg  <= '0;
			done_reg <= 1'b0;
			fire_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			done_reg <= active_i && (done_reg || reach);
			fire_reg <= reach;
		end
	end
endmodule
`default_nettype wire

// File: design/scan_sequencer.sv
// periodic on-window generator for the external temperature scan
`timescale 1ns/100ps
`default_nettype none
module scan_sequencer #(
	parameter int unsigned WIDTH = 32
) (
	// clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic             clr_i,       // synchronous clear
	// timing
	input  wire logic             enable_i,    // periodic scan allowed
	input  wire logic [WIDTH-1:0] on_cyc_i,    // length of the on window
	input  wire logic [WIDTH-1:0] period_cyc_i,// full period
	// result
	output logic                  scan_on_o    // level, high during the window
);
	logic [WIDTH-1:0] cnt_reg;                 // position inside the period
	logic [WIDTH-1:0] cnt_next;
	logic             wrap;
	logic             on_reg;

	assign wrap      = (cnt_reg + 1'b1) >= period_cyc_i;
	assign cnt_next  = (!enable_i || wrap) ? '0 : cnt_reg + 1'b1;
	assign scan_on_o = on_reg;

	// window opens at the start of each period; disabling restarts the period
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			on_reg  <= 1'b0;
		end else if (clr_i) begin
			cnt_reg <= '0;
			on_reg  <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			// judged on the count before it advances, so the first window after enable is full
			on_reg  <= enable_i && (cnt_reg < on_cyc_i);
		end
	end
endmodule
`default_nettype wire

// File: dv/pack_host_model.sv
// host model: single-cycle register strobes as the serial front end delivers them
`timescale 1ns/100ps
`default_nettype none
module pack_host_model
	import pack_prot_pkg::*;
(
	// clock
	input  wire logic       ref_clk_i,
	// register port
	output var reg_access_s req_o,
	input  wire logic [7:0] rdata_i
);
	// idle; the host never sleeps, so a set wake block cannot strand it
	initial req_o = '0;
	// write after gap + 1 idle cycles; released fields show inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
		repeat (gap + 1) @(negedge ref_clk_i);
		req_o = {2'b10, a, d};
		@(negedge ref_clk_i);
		req_o = {2'b00, ~a, ~d};
	endtask
	// read; data stands until the next read, so a late look is safe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk_i);
		req_o = {2'b01, a, 8'h00};
		@(negedge ref_clk_i);
		req_o = {2'b00, ~a, 8'hFF};
		@(negedge ref_clk_i);
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// File: dv/pack_prot_asserts.sv
// port-level checks for the pack protection configuration block
`timescale 1ns/100ps
`default_nettype none
module pack_prot_asserts
	import pack_prot_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	// register port
	input wire reg_access_s reg_req_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        dis_cfg_wr_o,
	input wire logic [7:0]  dis_cfg_wdata_o,
	// conditions
	input wire logic        chg_oc_detect_i,
	input wire logic        short_detect_i,
	input wire logic        ext_overtemp_i,
	input wire logic        int_overtemp_i,
	input wire logic        wake_pin_i,
	// results
	input wire logic        chg_overcurrent_flag_o,
	input wire logic        ext_overtemp_flag_o,
	input wire logic        int_overtemp_flag_o,
	input wire logic        fet_shutdown_o,
	input wire logic        charge_switch_clear_o,
	input wire logic        short_trip_o,
	input wire logic [1:0]  chg_oc_threshold_o,
	input wire logic [7:0]  chg_oc_threshold_mv_o,
	input wire logic        sensor_supply_out_o,
	input wire logic        wake_o
);
	// one clock domain, so defaults once
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// charge flag has just come up
	sequence s_oc_set;
		$rose(chg_overcurrent_flag_o);
	endsequence
	// host reads the write-enable byte
	sequence s_wen_read;
		reg_req_i.rd && reg_req_i.addr == ADDR_WEN;
	endsequence
	property p_oc_cause;
		s_oc_set |-> $past(chg_oc_detect_i);
	endproperty
	a_oc_cause: assert property (p_oc_cause)
		else $error("charge flag rose without detect");
	property p_oc_sup;
		s_oc_set |=> sensor_supply_out_o;
	endproperty
	a_oc_sup: assert property (p_oc_sup)
		else $error("sensor supply not on after charge flag");
	// threshold ladder settles once the code has held still
	property p_thr;
		$stable(chg_oc_threshold_o)[*3] |->
			chg_oc_threshold_mv_o == THR_BASE_MV + THR_STEP_MV * chg_oc_threshold_o;
	endproperty
	a_thr: assert property (p_thr)
		else $error("threshold millivolts wrong");
	property p_clr;
		charge_switch_clear_o |-> fet_shutdown_o && chg_overcurrent_flag_o
			##1 !charge_switch_clear_o;
	endproperty
	a_clr: assert property (p_clr)
		else $error("charge switch clear not a pulse with shutdown");
	property p_xot;
		ext_overtemp_i |-> ##[1:2] ext_overtemp_flag_o;
	endproperty
	a_xot: assert property (p_xot)
		else $error("external overtemp flag missing");
	property p_iot;
		int_overtemp_i |-> ##[1:2] int_overtemp_flag_o;
	endproperty
	a_iot: assert property (p_iot)
		else $error("internal overtemp flag missing");
	property p_wake;
		wake_o |-> $past(wake_pin_i) != $past(wake_pin_i, 2);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake without pin edge");
	property p_wen;
		s_wen_read |=> reg_rdata_o[2:0] == 3'h0;
	endproperty
	a_wen: assert property (p_wen)
		else $error("reserved enable bits read nonzero");
	property p_dwr;
		dis_cfg_wr_o |-> $past(reg_req_i.wr) && $past(reg_req_i.addr) == ADDR_DIS_CFG
			&& dis_cfg_wdata_o == $past(reg_req_i.data);
	endproperty
	a_dwr: assert property (p_dwr)
		else $error("discharge forward without write");
	property p_trip;
		short_trip_o |-> $past(short_detect_i) ##1 !short_trip_o;
	endproperty
	a_trip: assert property (p_trip)
		else $error("short trip without short");
endmodule
bind pack_protection_config_regs pack_prot_asserts i_pack_prot_asserts (.*);
`default_nettype wire

// File: dv/tb_pack_protection_config_regs.sv
// self-checking bench for the pack protection configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_pack_protection_config_regs;
	import pack_prot_pkg::*;
	// shortened counts keep the run brief
	localparam int CB = 64, DB = 128, SL = 20, SO = 4, SP = 40;
	logic        ref_clk_i, rst_i;
	reg_access_s req;            // host request
	logic [7:0]  rdata, dwd, mv, a, d, v;
	logic [1:0]  det, ot, dcode, thr; // detects, overtemps, discharge code
	logic [2:0]  clr;            // flag clears
	logic        pin, dwr, cclr, fet, trip, sup, rdis, wake, cflag, xflag, iflag;
	logic [31:0] ccyc, dcyc;
	int          n_mismatch, n_compared, seed, cyc, c, c2, k, cw, cs;
	int          m [6:8];        // model of registers 06 to 08
	pack_protection_config_regs #(
		.CHG_OC_BASE_CYCLES(CB), .DIS_OC_BASE_CYCLES(DB), .SHORT_LONG_CYCLES(SL),
		.SCAN_ON_CYCLES(SO), .SCAN_PERIOD_CYCLES(SP)
	) i_pack_protection_config_regs (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.dis_cfg_wr_o(dwr), .dis_cfg_wdata_o(dwd), .dis_oc_delay_code_i(dcode),
		.dis_oc_delay_cycles_o(dcyc), .chg_oc_detect_i(det[0]), .short_detect_i(det[1]),
		.ext_overtemp_i(ot[0]), .int_overtemp_i(ot[1]), .wake_pin_i(pin),
		.chg_oc_flag_clr_i(clr[0]), .ext_ot_flag_clr_i(clr[1]), .int_ot_flag_clr_i(clr[2]),
		.chg_overcurrent_flag_o(cflag), .ext_overtemp_flag_o(xflag),
		.int_overtemp_flag_o(iflag), .fet_shutdown_o(fet), .charge_switch_clear_o(cclr),
		.short_trip_o(trip), .chg_oc_threshold_o(thr), .chg_oc_threshold_mv_o(mv),
		.chg_oc_delay_cycles_o(ccyc), .sensor_supply_out_o(sup),
		.regulator_disable_o(rdis), .wake_o(wake)
	);
	pack_host_model i_pack_host_model (.ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata));
	// 20 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	// hang guard, well above the roughly 5000 cycles the run needs
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 10000) begin
			n_mismatch++;
			stop_test;
		end
	end
	task check(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task stop_test;
		if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// write through the host and track the lock gating in the model
	task tw(input logic [7:0] ad, input logic [7:0] dd);
		i_pack_host_model.wr(ad, dd, {$random(seed)} % 3);
		if (ad == ADDR_WEN) m[8] = dd & 8'hF8;
		if (ad == ADDR_CHG_CFG && m[8][6]) m[6] = dd;
		if (ad == ADDR_FEAT_CFG && m[8][7]) m[7] = dd & 8'hFB;
		if (ad == ADDR_DIS_CFG) check(dwr, m[8][5]);
		if (ad == ADDR_DIS_CFG && m[8][5]) check(dwd, dd);
	endtask
	// read back; anything outside 06 to 08 reads zero
	task tr(input logic [7:0] ad);
		i_pack_host_model.rd(ad, v);
		check(v, (ad > 8'h05 && ad < 8'h09) ? m[ad] : 0);
	endtask
	// decoded outputs against the model once settled
	task outs;
		repeat (2) @(negedge ref_clk_i);
		check(thr, m[6][6:5]);
		check(mv, 100 + 20 * m[6][6:5]);
		check(ccyc, (CB << m[6][1:0]) >> (m[6][3] ? 5 : 0));
		check(dcyc, (DB << dcode) >> (m[6][2] ? 6 : 0));
		check(rdis, m[7][6]);
		if (m[7][5]) check(sup, 1);
	endtask
	// hold a detect until its result shows, counting cycles
	task run(input int w, input int n);
		det[w] = 1'b1;
		c = 0;
		while (c < n + 4 && (w ? trip : cflag) !== 1'b1) begin
			@(negedge ref_clk_i);
			c++;
		end
		det[w] = 1'b0;
	endtask
	// count wake pulses and supply-on cycles
	task tally(input int n);
		cw = 0;
		cs = 0;
		repeat (n) begin
			@(negedge ref_clk_i);
			cw += (wake === 1'b1);
			cs += (sup === 1'b1);
		end
	endtask
	initial begin
		{seed, rst_i, det, ot, dcode, clr, pin} = {32'hB5E1, 1'b1, 10'h000};
		{n_mismatch, n_compared, cyc, m[6], m[7], m[8]} = '0;
		repeat (16) @(negedge ref_clk_i);
		rst_i = 1'b0;
		// power-up: all zero, locks shut, unmapped byte too
		for (k = 6; k <= 9; k++) tr(k[7:0]);
		tw(ADDR_CHG_CFG, 8'hFF);
		tw(ADDR_FEAT_CFG, 8'hFF);
		tw(ADDR_DIS_CFG, 8'h5A);
		tw(ADDR_WEN, 8'hFF);
		for (k = 6; k <= 9; k++) tr(k[7:0]);
		// random traffic; forced reset kept out of the mix
		for (k = 0; k < 24; k++) begin
			a = 8'(5 + {$random(seed)} % 4);
			d = 8'($random(seed));
			if (a == ADDR_FEAT_CFG) d[2] = 1'b0;
			dcode = 2'($random(seed));
			tw(a, d);
			if (a != ADDR_DIS_CFG) tr(a);
			outs;
		end
		tw(ADDR_WEN, 8'hE0);
		// overtemp: flag always, shutdown only when not disabled
		for (k = 0; k < 4; k++) begin
			tw(ADDR_FEAT_CFG, k[0] ? 8'h98 : 8'h80);
			ot[k[1]] = 1'b1;
			repeat (3) @(negedge ref_clk_i);
			check(k[1] ? iflag : xflag, 1);
			check(fet, !k[0]);
			ot = 2'b00;
			clr = 3'h6;
			@(negedge ref_clk_i);
			clr = 3'h0;
		end
		// wake: both polarities, blocked and open
		for (k = 0; k < 4; k++) begin
			tw(ADDR_FEAT_CFG, 8'h80 | k[1:0]);
			pin = !k[0];
			repeat (3) @(negedge ref_clk_i);
			pin = k[0];
			tally(3);
			check(cw, !k[1]);
			pin = !k[0];
			tally(3);
			check(cw, 0);
		end
		// periodic scan, then stopped
		tw(ADDR_FEAT_CFG, 8'h00);
		tally(2 * SP);
		check(cs, 2 * SO);
		tw(ADDR_FEAT_CFG, 8'h80);
		repeat (2) @(negedge ref_clk_i);
		tally(2 * SP);
		check(cs, 0);
		// charge overcurrent: auto off plain, then override with divide by 32
		for (k = 0; k < 2; k++) begin
			tw(ADDR_CHG_CFG, k ? 8'h8B : 8'h00);
			c2 = k ? 16 : CB;
			det[0] = 1'b1;
			repeat (c2 - 1) @(negedge ref_clk_i);
			det[0] = 1'b0;
			repeat (3) @(negedge ref_clk_i);
			check(cflag, 0);
			run(0, c2);
			check(c, c2 + 1);
			check(cclr, !k);
			check(fet, !k);
			@(negedge ref_clk_i);
			check(sup, 1);
			clr = 3'h1;
			@(negedge ref_clk_i);
			clr = 3'h0;
		end
		// short circuit, short and long persistence
		tw(ADDR_CHG_CFG, 8'h00);
		run(1, 3800);
		check(c, SHORT_SHORT_CYC + 1);
		tw(ADDR_CHG_CFG, 8'h10);
		run(1, SL);
		check(c, SL + 1);
		// user flags kept with the regulator off; external supply assumed
		tw(ADDR_WEN, 8'hF8);
		tw(ADDR_FEAT_CFG, 8'hC0);
		outs;
		tr(ADDR_WEN);
		// forced reset clears the config registers, locks included
		tw(ADDR_FEAT_CFG, 8'h04);
		{m[6], m[7], m[8]} = '0;
		repeat (3) @(negedge ref_clk_i);
		for (k = 6; k <= 8; k++) tr(k[7:0]);
		check(rdis, 0);
		tw(ADDR_CHG_CFG, 8'hFF);
		tr(ADDR_CHG_CFG);
		stop_test;
	end
endmodule
`default_nettype wire
